/* File: verilog/mspc_pkg.sv */
// Package of constants for the microstep position counter.
package mspc_pkg;
  // ******************************************************************
  // Counter geometry
  // ******************************************************************
  localparam int MSPC_CNT_W = 10;
  localparam logic [9:0] MSPC_CNT_RESET = 10'h000;
  localparam logic [9:0] MSPC_STEP_8 = 10'h020;
  localparam logic [9:0] MSPC_STEP_16 = 10'h010;
  localparam logic [9:0] MSPC_STEP_32 = 10'h008;
  localparam logic [9:0] MSPC_STEP_64 = 10'h004;
  localparam logic [9:0] MSPC_FULL_MASK = 10'h0ff;
  localparam logic [9:0] MSPC_FULL_VAL = 10'h080;
  localparam logic [7:0] MSPC_RES_8 = 8'h08;
  localparam logic [7:0] MSPC_RES_16 = 8'h10;
  localparam logic [7:0] MSPC_RES_32 = 8'h20;
  localparam logic [7:0] MSPC_RES_64 = 8'h40;

  // ******************************************************************
  // APB register map (byte addresses)
  // ******************************************************************
  localparam logic [7:0] MSPC_ADDR_COUNT = 8'h00;
  localparam logic [7:0] MSPC_ADDR_STATUS = 8'h04;
  localparam logic [7:0] MSPC_ADDR_CTRL = 8'h08;
  localparam int MSPC_ST_FULL = 0;
  localparam int MSPC_ST_STBY = 1;
  localparam int MSPC_ST_ENA = 2;
  localparam int MSPC_ST_RES_LSB = 8;
  localparam int MSPC_CTRL_HOLD = 0;
  localparam logic [31:0] MSPC_CTRL_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    MSPC_ACTIVE = 2'b00,
    MSPC_STANDBY = 2'b01
  } mspc_state_t;
endpackage : mspc_pkg

/* File: verilog/mspc_step_edge.sv */
// Rising-edge detector for the step input.
`timescale 1ns/1ps
module mspc_step_edge
  import mspc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic clear_n,
  input wire logic step_in,
  output logic step_pulse
);
  logic step_q;

  // Remember the last level; cleared whenever the unit is powered down.
  always_ff @(posedge ref_clk)
  begin
    if (!clear_n)
    begin
      step_q <= 1'b0;
      step_pulse <= 1'b0;
    end
    else
    begin
      step_q <= step_in;
      step_pulse <= step_in & ~step_q;
    end
  end
endmodule : mspc_step_edge

/* File: verilog/mspc_counter.sv */
// Microstep position counter with standby control and APB registers.
`timescale 1ns/1ps
module mspc_counter
  import mspc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic standby,
  input wire logic step,
  input wire logic dir,
  input wire logic drive_off_n,
  input wire logic resolution_sel_lo,
  input wire logic resolution_sel_hi,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [9:0] microstep_phase_count,
  output logic fullstep_pos,
  output logic units_on
);
  // ******************************************************************
  // Decoding helpers
  // ******************************************************************

  // Step increment for the pin-selected resolution.
  function automatic logic [9:0] step_size(input logic lo, input logic hi);
    case ({hi, lo})
      2'b00: step_size = MSPC_STEP_8;
      2'b01: step_size = MSPC_STEP_32;
      2'b10: step_size = MSPC_STEP_64;
      default: step_size = MSPC_STEP_16;
    endcase
  endfunction : step_size

  // Resolution number for status readback.
  function automatic logic [7:0] res_num(input logic lo, input logic hi);
    case ({hi, lo})
      2'b00: res_num = MSPC_RES_8;
      2'b01: res_num = MSPC_RES_32;
      2'b10: res_num = MSPC_RES_64;
      default: res_num = MSPC_RES_16;
    endcase
  endfunction : res_num

  // ******************************************************************
  // Standby state
  // ******************************************************************
  mspc_state_t state;
  mspc_state_t next_state;
  logic clear_n;
  logic step_pulse;
  logic [9:0] next_count;
  logic [31:0] ctrl;
  logic [7:0] byte_addr;
  logic apb_access;
  logic apb_done;

  // Standby follows the pin; any standby cycle clears the counter, step detector and control register, but not the APB outputs.
  always_comb
  begin
    case (standby)
      1'b1: next_state = MSPC_STANDBY;
      1'b0: next_state = MSPC_ACTIVE;
      default: next_state = MSPC_ACTIVE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      state <= MSPC_ACTIVE;
    else
      state <= next_state;
  end

  // Internal units are held in reset at power-up and while in standby.
  assign clear_n = resetn & ~standby;

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      units_on <= 1'b0;
    else
      units_on <= ~standby;
  end

  mspc_step_edge u_edge (
    .ref_clk(ref_clk),
    .clear_n(clear_n),
    .step_in(step),
    .step_pulse(step_pulse)
  );

  // ******************************************************************
  // Microstep counter
  // ******************************************************************

  // Add or subtract the step size; ten bits wrap by themselves.
  always_comb
  begin
    next_count = microstep_phase_count;
    if (step_pulse && !ctrl[MSPC_CTRL_HOLD])
    begin
      if (!dir)
        next_count = microstep_phase_count +
          step_size(resolution_sel_lo, resolution_sel_hi);
      else
        next_count = microstep_phase_count -
          step_size(resolution_sel_lo, resolution_sel_hi);
    end
  end

  // Counter restarts at zero, so n/2 steps land on 128 and multiples
  // of 4n land back on zero.
  always_ff @(posedge ref_clk)
  begin
    if (!clear_n)
      microstep_phase_count <= MSPC_CNT_RESET;
    else
      microstep_phase_count <= next_count;
  end

  // Fullstep positions are those whose low eight bits equal 128.
  always_ff @(posedge ref_clk)
  begin
    if (!clear_n)
      fullstep_pos <= 1'b0;
    else
      fullstep_pos <= (next_count & MSPC_FULL_MASK) == MSPC_FULL_VAL;
  end

  // ******************************************************************
  // APB slave
  // ******************************************************************
  assign byte_addr = paddr[7:0];
  assign apb_access = psel & penable & ~pready;
  // The transfer completes at the edge where pready is seen high.
  assign apb_done = psel & penable & pready;

  // Control register; the hold bit freezes counting for diagnostics.
  // A write lands only when the transfer completes, never earlier.
  always_ff @(posedge ref_clk)
  begin
    if (!clear_n)
      ctrl <= MSPC_CTRL_RESET;
    else if (apb_done && pwrite && paddr[31:8] == 24'h000000 &&
             byte_addr == MSPC_ADDR_CTRL)
      ctrl <= {31'h00000000, pwdata[MSPC_CTRL_HOLD]};
  end

  // One wait state: pready rises in the second cycle after the setup phase.
  // Reads still answer in standby so the controller sees the state.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (apb_access)
    begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (paddr[31:8] != 24'h000000)
        pslverr <= 1'b1;
      else
      begin
        case (byte_addr)
          MSPC_ADDR_COUNT:
            if (!pwrite)
              prdata <= {22'h000000, microstep_phase_count};
            else
              pslverr <= 1'b1;
          MSPC_ADDR_STATUS:
            if (!pwrite)
            begin
              prdata[MSPC_ST_FULL] <= fullstep_pos;
              prdata[MSPC_ST_STBY] <= state == MSPC_STANDBY;
              prdata[MSPC_ST_ENA] <= ~drive_off_n;
              prdata[MSPC_ST_RES_LSB +: 8] <=
                res_num(resolution_sel_lo, resolution_sel_hi);
            end
            else
              pslverr <= 1'b1;
          MSPC_ADDR_CTRL:
            if (!pwrite)
              prdata <= ctrl;
          default:
            pslverr <= 1'b1;
        endcase
      end
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  up_step_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (step_pulse && !dir && !standby && !ctrl[0] &&
     {resolution_sel_hi, resolution_sel_lo} == 2'b00)
    |=> microstep_phase_count == $past(microstep_phase_count) + 10'h020)
    else $error("upward step size wrong");
  dir_up_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (step_pulse && !dir && !standby && !ctrl[0] &&
     {resolution_sel_hi, resolution_sel_lo} == 2'b01)
    |=> microstep_phase_count == $past(microstep_phase_count) + 10'h008)
    else $error("low direction did not count up");
  down_step_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (step_pulse && dir && !standby && !ctrl[0] &&
     {resolution_sel_hi, resolution_sel_lo} == 2'b10)
    |=> microstep_phase_count == $past(microstep_phase_count) - 10'h004)
    else $error("high direction did not count down");
  res_sel_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (step_pulse && !dir && !standby && !ctrl[0] &&
     {resolution_sel_hi, resolution_sel_lo} == 2'b11)
    |=> microstep_phase_count == $past(microstep_phase_count) + 10'h010)
    else $error("resolution select wrong");
  stby_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    standby |=> microstep_phase_count == 10'h000 && ctrl == 32'h0 &&
    !units_on)
    else $error("standby did not clear state");
  wake_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(standby) |-> microstep_phase_count == 10'h000 ##1
    microstep_phase_count == 10'h000)
    else $error("counter not zero after standby");
  full_pos_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    fullstep_pos |-> microstep_phase_count[7:0] == 8'h80)
    else $error("fullstep flag off a fullstep value");
  zero_pos_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    microstep_phase_count == 10'h000 |-> !fullstep_pos)
    else $error("zero position flagged as fullstep");
endmodule : mspc_counter

/* File: verification/mspc_ctrl_model.sv */
// Behavioural motion controller driving step, direction, enable, standby.
`timescale 1ns/1ps
module mspc_ctrl_model
(
  input wire logic ref_clk,
  output logic step,
  output logic dir,
  output logic drive_off_n,
  output logic standby
);
  // Motor at rest, driver off and device awake at time zero.
  initial
  begin
    step = 1'b0;
    dir = 1'b0;
    drive_off_n = 1'b1;
    standby = 1'b0;
  end

  // Random pulse widths test both prompt and slow step trains.
  task automatic move(input int n, input logic d);
    int i;
    @(posedge ref_clk);
    dir <= d;
    for (i = 0; i < n; i++)
    begin
      @(posedge ref_clk);
      step <= 1'b1;
      repeat ($urandom_range(3, 1)) @(posedge ref_clk);
      step <= 1'b0;
      repeat ($urandom_range(3, 1)) @(posedge ref_clk);
    end
    repeat (3) @(posedge ref_clk);
  endtask : move

  // Only called with the step line idle, so the motor is stopped.
  task automatic sleep(input logic on);
    @(posedge ref_clk);
    standby <= on;
    drive_off_n <= ~on;
  endtask : sleep

  // The driver is enabled here after the restoring steps; sleep also enables it on entering standby.
  task automatic enable_drive();
    @(posedge ref_clk);
    drive_off_n <= 1'b0;
  endtask : enable_drive
endmodule : mspc_ctrl_model

/* File: verification/microstep_position_counter_tb_top.sv */
// Self-checking bench for the microstep position counter.
`timescale 1ns/1ps
module microstep_position_counter_tb_top
  import mspc_pkg::*;
();
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] code = 2'h0;
  logic step, dir, drive_off_n, standby, pready, pslverr;
  logic fullstep_pos, units_on, er;
  logic [31:0] prdata, rd;
  logic [9:0] count, exp;
  int num_errors = 0;
  int n_checks = 0;
  int n;

  // Free-running 40 MHz clock.
  always #12.5 ref_clk = ~ref_clk;

  mspc_ctrl_model u_mspc_ctrl_model (.ref_clk(ref_clk), .step(step),
    .dir(dir), .drive_off_n(drive_off_n), .standby(standby));
  mspc_counter u_mspc_counter (.ref_clk(ref_clk), .resetn(resetn),
    .standby(standby), .step(step), .dir(dir), .drive_off_n(drive_off_n),
    .resolution_sel_lo(code[0]), .resolution_sel_hi(code[1]),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .microstep_phase_count(count),
    .fullstep_pos(fullstep_pos), .units_on(units_on));

  // Case inequality so that an unknown never counts as a match.
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  // Reads at the edge see pre-edge values, so pready is sampled there.
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for an answer that never comes.
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Resolution selected by the two pins; mv derives the step size from it.
  function automatic int res_of(input logic [1:0] c);
    return (c == 2'h0) ? 8 : (c == 2'h1) ? 32 : (c == 2'h2) ? 64 : 16;
  endfunction : res_of

  // Moves the motor and checks the counter against the running model.
  task automatic mv(input int k, input logic d);
    logic [9:0] inc;
    inc = 10'(256 / res_of(code));
    u_mspc_ctrl_model.move(k, d);
    exp = d ? exp - 10'(k * inc) : exp + 10'(k * inc);
    chk("count", {22'h0, exp}, {22'h0, count});
  endtask : mv

  // A hang beyond the expected run length ends the test as a failure.
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    stop_test();
  end

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial
  begin
    int c;
    void'($urandom(32'h23df));
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    // Outputs launched at the first edge are only seen at the second.
    repeat (2) @(posedge ref_clk);
    chk("count", 32'h0, {22'h0, count});
    chk("units", 32'h1, {31'h0, units_on});
    apb(1'b0, MSPC_ADDR_CTRL, 32'h0);
    chk("ctrl", MSPC_CTRL_RESET, rd);
    for (c = 0; c < 4; c++)
    begin
      code <= c[1:0];
      n = res_of(c[1:0]);
      u_mspc_ctrl_model.sleep(1'b1);
      repeat (3) @(posedge ref_clk);
      chk("units", 32'h0, {31'h0, units_on});
      apb(1'b0, MSPC_ADDR_STATUS, 32'h0);
      chk("stby", 32'h1, {31'h0, rd[1]});
      u_mspc_ctrl_model.move(2, 1'b0);
      u_mspc_ctrl_model.sleep(1'b0);
      repeat (3) @(posedge ref_clk);
      chk("count", 32'h0, {22'h0, count});
      apb(1'b0, MSPC_ADDR_CTRL, 32'h0);
      chk("ctrl", MSPC_CTRL_RESET, rd);
      exp = 10'h0;
      mv(4 * n, 1'b0);
      mv(n / 2, 1'b0);
      chk("full", 32'h1, {31'h0, fullstep_pos});
      mv(n, 1'b0);
      apb(1'b0, MSPC_ADDR_STATUS, 32'h0);
      chk("res", 32'(n), {24'h0, rd[15:8]});
      chk("fullbit", 32'h1, {31'h0, rd[0]});
      mv($urandom_range(n, 1), 1'($urandom_range(1, 0)));
      mv(n, 1'b1);
      apb(1'b0, MSPC_ADDR_COUNT, 32'h0);
      chk("reg", {22'h0, exp}, rd);
      chk("err", 32'h0, {31'h0, er});
      apb(1'b1, MSPC_ADDR_CTRL, 32'h1);
      mv(0, 1'b0);
      u_mspc_ctrl_model.move(3, 1'b0);
      chk("hold", {22'h0, exp}, {22'h0, count});
      apb(1'b1, MSPC_ADDR_COUNT, 32'h5);
      chk("err", 32'h1, {31'h0, er});
      apb(1'b0, 8'h0c, 32'h0);
      chk("err", 32'h1, {31'h0, er});
      u_mspc_ctrl_model.enable_drive();
      apb(1'b0, MSPC_ADDR_STATUS, 32'h0);
      chk("ena", 32'h1, {31'h0, rd[2]});
      chk("stby", 32'h0, {31'h0, rd[1]});
    end
    stop_test();
  end
endmodule : microstep_position_counter_tb_top
